// >>> hw/pll_clock_network.sv
// clock synthesis loop, output chain and global buffer network
//
// Operation
// [R1] bypass 0 sends the synthesized clock out, bypass 1 the raw reference.
// [R2] the output divider divides by 1, 2, 4, 8, 16, 32 or 64.
// [R3] a feedback divider makes the synthesized clock a multiple of the ref.
// [R4] lock rises after phase alignment and falls whenever it is lost.
// [R5] in dynamic mode the 8-bit fabric delay input sets the phase shift.
// [R6] a dynamic shift on the fed-back output drops lock until relocked.
// [R7] external feedback is used only when selected, else internal.
// [R8] hold with both gate enables set freezes the output at its level.
// [R9] the global output can drive the clock network via buffers 4 and 5.
// [R10] the fabric output runs at the same frequency as the global one.
// [R11] the reference comes from a pin, a strobe generator or fabric.
// [R12] any of the eight buffers can drive a logic block clock.
// [R13] at most four buffers feed a logic block's lookup inputs.
// [R14] even buffers drive set/reset and odd ones clock enable.
// [R15] buffers 7,6,3..0 take the global pins, 4 slow and 5 fast strobe.
// [R16] six global pins serve as plain inputs when not driving a clock.
// [R17] while the loop reset is low the loop is held and lock stays low.
`timescale 1ns/1ps
module pll_clock_network
   import pll_clk_pkg::*;
#(
   parameter int RELOCK_WAIT_CYCLES = RELOCK_WAIT_CYC,
   parameter int DELAY_TAPS = 256
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // reference sources
   input wire logic refPin,
   input wire logic slowStrobeGen,
   input wire logic fastStrobeGen,
   input wire logic fabricRefClock,
   // loop control from fabric
   input wire logic pllResetN,
   input wire logic bypass,
   input wire logic lowPowerHold,
   input wire logic [7:0] fineDelayControl,
   input wire logic externalFeedbackIn,
   // loop outputs
   output logic pllGlobalOutput,
   output logic pllFabricOutput,
   output logic pllLock,
   // global network
   input wire logic [5:0] globalPin,
   output logic [7:0] globalBuffer,
   output logic [5:0] globalPinGpio,
   output logic plbClock,
   output logic [3:0] plbLutIn,
   output logic plbSetReset,
   output logic plbClockEnable,
   // interrupt
   output logic irq
);

   // elaboration checks
   if (RELOCK_WAIT_CYCLES < 1) begin : gChkWait
      $error("relock wait must be at least one cycle");
   end
   if (DELAY_TAPS != 256) begin : gChkTaps
      $error("delay line must match the 8-bit delay control");
   end

   ////////////////////////////////////////////////////////////////////////
   // declarations
   logic [31:0] ctrl_r, delay_r, global_buffer_r, route_r;
   logic [IRQ_W-1:0] irqStat_r, irqMask_r, irqEv;
   logic [7:0] syncA_r, syncB_r, syncC_r, clean_r, cleanPrev_r;
   logic refLvl, refLvlPrev_r, refRise, extRise;
   logic [PERIOD_W-1:0] refCnt_r, refPeriod_r;
   logic refOk_r, refLostEv;
   logic [PERIOD_W:0] acc_r;
   logic [PERIOD_W+1:0] accSum;
   logic [FBDIV_W:0] accStep;
   logic vco_r, vcoRise;
   logic [FBDIV_W-1:0] fbDiv, fbCnt_r;
   logic intFbPulse, fbEdge;
   logic [1:0] fbSeen_r;
   logic [5:0] divCnt_r;
   logic [DIV_SEL_W-1:0] divSel, divIdx;
   logic divLvl, tapLvl, outSel, hold;
   logic [DELAY_TAPS-1:0] dlyLine_r;
   logic [DELAY_W-1:0] dlyEff, dlyPrev_r;
   logic dlyChange;
   lockst_e state_r, state_nxt;
   logic [31:0] waitCnt_r;
   logic [3:0] goodCnt_r;
   logic [7:0] global_buffer_nxt;
   logic access, done;
   logic [31:0] rdMux;
   logic rdErr;

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers: bit0 ref pin, bit1 ext feedback, 7:2 global pins
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         syncA_r <= 8'h00;
         syncB_r <= 8'h00;
         syncC_r <= 8'h00;
      end else begin
         syncA_r <= {globalPin, externalFeedbackIn, refPin};
         syncB_r <= syncA_r;
         syncC_r <= syncB_r;
      end
   end

   // a level counts only once the second and third stages agree
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         clean_r <= 8'h00;
         cleanPrev_r <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (syncB_r[i] == syncC_r[i]) begin
               clean_r[i] <= syncB_r[i];
            end
         end
         cleanPrev_r <= clean_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reference selection and period measurement
   always_comb begin
      unique case (refsrc_e'(ctrl_r[CTRL_REF_LSB +: 2])) // see [R11]
         REF_PIN: refLvl = clean_r[0];
         REF_SLOW: refLvl = slowStrobeGen;
         REF_FABRIC: refLvl = fabricRefClock;
         REF_FAST: refLvl = fastStrobeGen;
      endcase
   end

   assign refRise = refLvl & ~refLvlPrev_r;
   assign extRise = clean_r[1] & ~cleanPrev_r[1];
   assign refLostEv = refOk_r & (&refCnt_r);

   // period counter saturates when the reference stops
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         refLvlPrev_r <= 1'b0;
         refCnt_r <= '0;
         refPeriod_r <= '0;
         refOk_r <= 1'b0;
      end else begin
         refLvlPrev_r <= refLvl;
         if (refRise) begin
            refCnt_r <= '0;
            refPeriod_r <= refCnt_r + 16'h0001;
            refOk_r <= 1'b1;
         end else if (!(&refCnt_r)) begin
            refCnt_r <= refCnt_r + 16'h0001;
         end else begin
            refOk_r <= 1'b0;
            refPeriod_r <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // synthesizer: 2*fbDiv toggles per reference period
   assign fbDiv = (ctrl_r[CTRL_FBDIV_LSB +: FBDIV_W] == '0) ? 6'h01 :
                  ctrl_r[CTRL_FBDIV_LSB +: FBDIV_W];
   assign accStep = {fbDiv, 1'b0};
   assign accSum = {1'b0, acc_r} + {{(PERIOD_W+1-FBDIV_W){1'b0}}, accStep};

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         acc_r <= '0;
         vco_r <= 1'b0;
      end else if (!pllResetN || !refOk_r) begin // see [R17]
         acc_r <= '0;
         vco_r <= 1'b0;
      end else if (accSum >= {2'b00, refPeriod_r}) begin // see [R3]
         acc_r <= (PERIOD_W+1)'(accSum - {2'b00, refPeriod_r});
         vco_r <= ~vco_r;
      end else begin
         acc_r <= accSum[PERIOD_W:0];
      end
   end

   assign vcoRise = (accSum >= {2'b00, refPeriod_r}) & ~vco_r &
                    pllResetN & refOk_r;

   // feedback divider: one pulse per fbDiv synthesized cycles
   assign intFbPulse = vcoRise & (fbCnt_r == fbDiv - 6'h01);
   assign fbEdge = ctrl_r[CTRL_FB_EXT] ? extRise : intFbPulse; // see [R7]

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fbCnt_r <= '0;
         fbSeen_r <= 2'h0;
      end else begin
         if (!pllResetN || intFbPulse) begin
            fbCnt_r <= '0;
         end else if (vcoRise) begin
            fbCnt_r <= fbCnt_r + 6'h01;
         end
         if (refRise) begin
            fbSeen_r <= {1'b0, fbEdge};
         end else if (fbEdge && fbSeen_r != 2'h3) begin
            fbSeen_r <= fbSeen_r + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output divider, powers of two up to 64
   assign divSel = (ctrl_r[CTRL_DIV_LSB +: DIV_SEL_W] > DIV_SEL_MAX) ?
                   DIV_SEL_MAX : ctrl_r[CTRL_DIV_LSB +: DIV_SEL_W];
   assign divIdx = divSel - 3'h1;
   assign divLvl = (divSel == 3'h0) ? vco_r : divCnt_r[divIdx]; // see [R2]

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         divCnt_r <= '0;
      end else if (!pllResetN) begin
         divCnt_r <= '0;
      end else if (vcoRise) begin
         divCnt_r <= divCnt_r + 6'h01;
      end
   end

   // fine delay line: static register or fabric input
   assign dlyEff = ctrl_r[CTRL_DLY_DYN] ? fineDelayControl : // see [R5]
                   delay_r[DELAY_W-1:0];
   assign tapLvl = (dlyEff == '0) ? divLvl : dlyLine_r[dlyEff - 8'h01];
   assign dlyChange = ctrl_r[CTRL_DLY_DYN] & (dlyEff != dlyPrev_r);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dlyLine_r <= '0;
         dlyPrev_r <= '0;
      end else begin
         dlyLine_r <= {dlyLine_r[DELAY_TAPS-2:0], divLvl};
         dlyPrev_r <= dlyEff;
      end
   end

   // bypass and low-power hold
   assign outSel = bypass ? refLvl : (tapLvl & pllResetN); // see [R1]
   assign hold = lowPowerHold & ctrl_r[CTRL_GATE_A] & ctrl_r[CTRL_GATE_B];

   // both outputs carry the same clock
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pllGlobalOutput <= 1'b0;
         pllFabricOutput <= 1'b0;
      end else if (!hold) begin // see [R8]
         pllGlobalOutput <= outSel;
         pllFabricOutput <= outSel; // see [R10]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // lock acquisition
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RESET: state_nxt = ST_WAIT;
         ST_WAIT: begin
            if (waitCnt_r == 32'h0) state_nxt = ST_ACQUIRE;
         end
         ST_ACQUIRE: begin
            if (refRise && fbSeen_r == 2'h1 &&
                goodCnt_r == 4'(LOCK_PERIODS - 1)) begin
               state_nxt = ST_LOCKED;
            end
         end
         ST_LOCKED: begin
            if (refRise && fbSeen_r != 2'h1) begin // see [R4]
               state_nxt = ST_ACQUIRE;
            end
            if (refLostEv) state_nxt = ST_ACQUIRE;
         end
         default: state_nxt = ST_RESET;
      endcase
      if (dlyChange && ctrl_r[CTRL_FB_EXT] && state_r != ST_RESET) begin
         state_nxt = ST_WAIT; // see [R6]
      end
      if (!pllResetN) state_nxt = ST_RESET; // see [R17]
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_r <= ST_RESET;
         waitCnt_r <= '0;
         goodCnt_r <= '0;
         pllLock <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pllLock <= (state_nxt == ST_LOCKED);
         if (state_nxt == ST_WAIT && state_r != ST_WAIT) begin
            waitCnt_r <= 32'(RELOCK_WAIT_CYCLES - 1);
         end else if (waitCnt_r != 32'h0) begin
            waitCnt_r <= waitCnt_r - 32'h1;
         end
         if (state_r != ST_ACQUIRE || (refRise && fbSeen_r != 2'h1)) begin
            goodCnt_r <= '0;
         end else if (refRise) begin
            goodCnt_r <= goodCnt_r + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // global buffer sources
   always_comb begin
      global_buffer_nxt = 8'h00;
      for (int i = 0; i < 4; i++) begin // see [R15]
         global_buffer_nxt[i] = clean_r[2+i] & global_buffer_r[GLOBAL_BUFFER_PIN_LSB+i];
      end
      global_buffer_nxt[6] = clean_r[6] & global_buffer_r[GLOBAL_BUFFER_PIN_LSB+4];
      global_buffer_nxt[7] = clean_r[7] & global_buffer_r[GLOBAL_BUFFER_PIN_LSB+5];
      global_buffer_nxt[4] = global_buffer_r[GLOBAL_BUFFER_B4_PLL] ? pllGlobalOutput : // see [R9]
                    slowStrobeGen;
      global_buffer_nxt[5] = global_buffer_r[GLOBAL_BUFFER_B5_PLL] ? pllGlobalOutput : fastStrobeGen;
   end

   // pins not used as clocks are handed to the fabric as plain inputs
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         globalBuffer <= 8'h00;
         globalPinGpio <= 6'h00;
      end else begin
         globalBuffer <= global_buffer_nxt;
         globalPinGpio <= clean_r[7:2] & // see [R16]
                          ~global_buffer_r[GLOBAL_BUFFER_PIN_LSB +: NUM_GPIN];
      end
   end

   // logic block connections
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         plbClock <= 1'b0;
         plbLutIn <= 4'h0;
         plbSetReset <= 1'b0;
         plbClockEnable <= 1'b0;
      end else begin
         plbClock <= globalBuffer[route_r[ROUTE_CLK_LSB +: 3]]; // see [R12]
         for (int i = 0; i < NUM_LUT_SEL; i++) begin // see [R13]
            plbLutIn[i] <= globalBuffer[route_r[ROUTE_LUT_LSB+3*i +: 3]];
         end
         plbSetReset <= globalBuffer[{route_r[ROUTE_SR_LSB +: 2], 1'b0}];
         plbClockEnable <= // see [R14]
            globalBuffer[{route_r[ROUTE_CE_LSB +: 2], 1'b1}];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, write lands on the completing edge
   assign access = psel & penable;
   assign done = access & pready;

   always_comb begin
      rdErr = 1'b0;
      rdMux = 32'h0;
      unique case (paddr)
         OFS_CTRL: rdMux = ctrl_r;
         OFS_DELAY: rdMux = delay_r;
         OFS_GLOBAL_BUFFER: rdMux = global_buffer_r;
         OFS_ROUTE: rdMux = route_r;
         OFS_STATUS: begin
            rdMux[STAT_LOCK] = pllLock;
            rdMux[STAT_REF_OK] = refOk_r;
            rdMux[STAT_PIN_LSB +: NUM_GPIN] = clean_r[7:2];
            rdMux[STAT_PERIOD_LSB +: PERIOD_W] = refPeriod_r;
         end
         OFS_IRQ_STAT: rdMux[IRQ_W-1:0] = irqStat_r;
         OFS_IRQ_MASK: rdMux[IRQ_W-1:0] = irqMask_r;
         default: rdErr = 1'b1;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= access & ~pready;
         prdata <= (access && !pready && !pwrite) ? rdMux : 32'h0;
         pslverr <= access & ~pready & rdErr;
      end
   end

   // writable registers
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl_r <= CTRL_RST;
         delay_r <= DELAY_RST;
         global_buffer_r <= GLOBAL_BUFFER_RST;
         route_r <= ROUTE_RST;
         irqMask_r <= MASK_RST;
      end else if (done && pwrite) begin
         unique case (paddr)
            OFS_CTRL: ctrl_r <= pwdata & 32'h003F_073F;
            OFS_DELAY: delay_r <= pwdata & 32'h0000_00FF;
            OFS_GLOBAL_BUFFER: global_buffer_r <= pwdata & 32'h0000_3F03;
            OFS_ROUTE: route_r <= pwdata & 32'h000F_FFF7;
            OFS_IRQ_MASK: irqMask_r <= pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupts: sticky, write one to clear, a new event wins over clear
   always_comb begin
      irqEv = '0;
      irqEv[IRQ_LOCK_GAIN] = (state_nxt == ST_LOCKED) & ~pllLock;
      irqEv[IRQ_LOCK_LOSS] = (state_nxt != ST_LOCKED) & pllLock;
      irqEv[IRQ_REF_LOST] = refLostEv;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irqStat_r <= '0;
         irq <= 1'b0;
      end else begin
         if (done && pwrite && paddr == OFS_IRQ_STAT) begin
            irqStat_r <= (irqStat_r & ~pwdata[IRQ_W-1:0]) | irqEv;
         end else begin
            irqStat_r <= irqStat_r | irqEv;
         end
         irq <= |(irqStat_r & irqMask_r);
      end
   end

endmodule

// >>> hw/pll_clk_pkg.sv
// constants, register map and field layout of the pll and global clock block
package pll_clk_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int RELOCK_WAIT_NS = 50000;
   localparam int RELOCK_WAIT_CYC =
      (RELOCK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_PERIODS = 8;

   // widths and counts
   localparam int FBDIV_W = 6;
   localparam int DIV_SEL_W = 3;
   localparam logic [2:0] DIV_SEL_MAX = 3'h6;
   localparam int DELAY_W = 8;
   localparam int PERIOD_W = 16;
   localparam int NUM_GLOBAL_BUFFER = 8;
   localparam int NUM_GPIN = 6;
   localparam int NUM_LUT_SEL = 4;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DELAY = 8'h04;
   localparam logic [7:0] OFS_GLOBAL_BUFFER = 8'h08;
   localparam logic [7:0] OFS_ROUTE = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

   // control register fields
   localparam int CTRL_REF_LSB = 0;
   localparam int CTRL_FB_EXT = 2;
   localparam int CTRL_DLY_DYN = 3;
   localparam int CTRL_GATE_A = 4;
   localparam int CTRL_GATE_B = 5;
   localparam int CTRL_DIV_LSB = 8;
   localparam int CTRL_FBDIV_LSB = 16;

   // global buffer and routing fields
   localparam int GLOBAL_BUFFER_B4_PLL = 0;
   localparam int GLOBAL_BUFFER_B5_PLL = 1;
   localparam int GLOBAL_BUFFER_PIN_LSB = 8;
   localparam int ROUTE_CLK_LSB = 0;
   localparam int ROUTE_LUT_LSB = 4;
   localparam int ROUTE_SR_LSB = 16;
   localparam int ROUTE_CE_LSB = 18;

   // status and interrupt fields
   localparam int STAT_LOCK = 0;
   localparam int STAT_REF_OK = 1;
   localparam int STAT_PIN_LSB = 8;
   localparam int STAT_PERIOD_LSB = 16;
   localparam int IRQ_W = 3;
   localparam int IRQ_LOCK_GAIN = 0;
   localparam int IRQ_LOCK_LOSS = 1;
   localparam int IRQ_REF_LOST = 2;

   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0001_0000;
   localparam logic [31:0] DELAY_RST = 32'h0000_0000;
   localparam logic [31:0] GLOBAL_BUFFER_RST = 32'h0000_3F00;
   localparam logic [31:0] ROUTE_RST = 32'h0000_0000;
   localparam logic [2:0] MASK_RST = 3'h0;

   // reference source choices
   typedef enum logic [1:0] {
      REF_PIN = 2'h0,
      REF_SLOW = 2'h1,
      REF_FABRIC = 2'h2,
      REF_FAST = 2'h3
   } refsrc_e;

   // loop acquisition states
   typedef enum logic [3:0] {
      ST_RESET = 4'h1,
      ST_WAIT = 4'h2,
      ST_ACQUIRE = 4'h4,
      ST_LOCKED = 4'h8
   } lockst_e;
endpackage

// >>> bench/fabric_model.sv
// fabric side model: reference sources and the external feedback wire
`timescale 1ns/1ps
module fabric_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // loop output routed back through the fabric
   input wire logic pllFabricOutput,
   // sources made on the fabric side
   output logic refPin,
   output logic fabricRefClock,
   output logic slowStrobeGen,
   output logic fastStrobeGen,
   output logic externalFeedbackIn
);
   logic [7:0] tick_r;
   logic [2:0] fast_r;

   // free running sources: ref period 16, slow 32, fast 12 cycles
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tick_r <= 8'h00;
         fast_r <= 3'h0;
         fastStrobeGen <= 1'b0;
      end else begin
         tick_r <= tick_r + 8'h01;
         fast_r <= (fast_r == 3'h5) ? 3'h0 : fast_r + 3'h1;
         if (fast_r == 3'h5) begin
            fastStrobeGen <= ~fastStrobeGen;
         end
      end
   end
   assign refPin = tick_r[3];
   assign fabricRefClock = tick_r[3];
   assign slowStrobeGen = tick_r[4];

   // feedback routing adds one register of delay
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         externalFeedbackIn <= 1'b0;
      end else begin
         externalFeedbackIn <= pllFabricOutput;
      end
   end
endmodule

// >>> bench/pll_clock_monitor.sv
// checker of the bus answers and loop outputs of the clock block
`timescale 1ns/1ps
module pll_clock_monitor (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // loop
   input wire logic pllResetN,
   input wire logic pllGlobalOutput,
   input wire logic pllFabricOutput,
   input wire logic pllLock
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("no answer after wait");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready held too long");
   property p_err; pslverr |-> pready && psel && penable; endproperty
   a_err: assert property (p_err) else $error("error outside answer");
   property p_quiet; !pready |-> prdata == 32'h0; endproperty
   a_quiet: assert property (p_quiet) else $error("read data not zero");
   property p_map;
      pready |-> pslverr == (paddr > 8'h18 || paddr[1:0] != 2'h0);
   endproperty
   a_map: assert property (p_map) else $error("address decode wrong");
   property p_held; !pllResetN ##1 !pllResetN |-> !pllLock; endproperty
   a_held: assert property (p_held) else $error("lock in reset");
   property p_acq; $rose(pllResetN) |-> !pllLock [*8]; endproperty
   a_acq: assert property (p_acq) else $error("lock too early");
   property p_same; pllGlobalOutput == pllFabricOutput; endproperty
   a_same: assert property (p_same) else $error("outputs differ");
endmodule

bind pll_clock_network pll_clock_monitor i_pll_clock_monitor (
   .clk_sys(clk_sys),
   .reset(reset),
   .psel(psel),
   .penable(penable),
   .paddr(paddr),
   .pready(pready),
   .prdata(prdata),
   .pslverr(pslverr),
   .pllResetN(pllResetN),
   .pllGlobalOutput(pllGlobalOutput),
   .pllFabricOutput(pllFabricOutput),
   .pllLock(pllLock)
);

// >>> bench/pll_clock_network_test.sv
// self-checking bench of the pll and global clock block
`timescale 1ns/1ps
module pll_clock_network_test;
   import pll_clk_pkg::*;
   logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, fineDelayControl = 8'h00, globalBuffer, eb;
   logic [31:0] pwdata = 32'h0, prdata, rdData;
   logic pready, pslverr, lastErr, pllResetN = 0, bypass = 0, hold = 0;
   logic refPin, slowStrobeGen, fastStrobeGen, fabricRefClock, extFb;
   logic [5:0] globalPin = 6'h00, globalPinGpio;
   logic pllGlobalOutput, pllFabricOutput, pllLock, plbClock, irq;
   logic plbSetReset, plbClockEnable, v;
   logic [3:0] plbLutIn;
   logic [31:0] ctl[7] = '{32'h10000, 32'h20000, 32'h40000, 32'h40100,
      32'h40200, 32'h40600, 32'h40700};
   int exP[7] = '{16, 8, 4, 8, 16, 256, 256};
   int srcP[4] = '{16, 32, 16, 12};
   int err_count = 0, total_checks = 0, p;

   always #4 clk_sys = ~clk_sys;

   pll_clock_network #(.RELOCK_WAIT_CYCLES(20)) i_pll_clock_network (
      .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .refPin(refPin),
      .slowStrobeGen(slowStrobeGen), .fastStrobeGen(fastStrobeGen),
      .fabricRefClock(fabricRefClock), .pllResetN(pllResetN),
      .bypass(bypass), .lowPowerHold(hold),
      .fineDelayControl(fineDelayControl), .externalFeedbackIn(extFb),
      .pllGlobalOutput(pllGlobalOutput), .pllFabricOutput(pllFabricOutput),
      .pllLock(pllLock), .globalPin(globalPin), .globalBuffer(globalBuffer),
      .globalPinGpio(globalPinGpio), .plbClock(plbClock),
      .plbLutIn(plbLutIn), .plbSetReset(plbSetReset),
      .plbClockEnable(plbClockEnable), .irq(irq));

   fabric_model i_fabric_model (
      .clk_sys(clk_sys), .reset(reset), .pllFabricOutput(pllFabricOutput),
      .refPin(refPin), .fabricRefClock(fabricRefClock),
      .slowStrobeGen(slowStrobeGen), .fastStrobeGen(fastStrobeGen),
      .externalFeedbackIn(extFb));

   ////////////////////////////////////////////////////////////////////////
   // comparison and verdict
   task automatic check(input string nm, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic test_done;
      if (err_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // one bus transfer, request held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) check("bus answer", 0, 1);
      rdData = prdata;
      lastErr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input string nm);
      apb(0, a, 32'h0);
      check(nm, rdData, e);
   endtask

   task automatic waitLock(input logic want);
      int n;
      n = 0;
      while (pllLock !== want && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
   endtask

   // cycles between rising edges of the global output, second period
   task automatic per;
      int n;
      n = 0;
      repeat (300) @(posedge clk_sys); // let the delay line flush
      repeat (2) begin
         p = 0;
         while (pllGlobalOutput !== 1'b0 && n < 2000) begin
            @(posedge clk_sys);
            n++;
            p++;
         end
         while (pllGlobalOutput !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            n++;
            p++;
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      repeat (80000) @(posedge clk_sys);
      err_count++;
      test_done;
   end

   // test sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 0;
      rd(OFS_CTRL, CTRL_RST, "ctrl");
      rd(OFS_DELAY, DELAY_RST, "delay");
      rd(OFS_GLOBAL_BUFFER, GLOBAL_BUFFER_RST, "global_buffer");
      rd(OFS_ROUTE, ROUTE_RST, "route");
      rd(OFS_IRQ_MASK, 32'h0, "mask");
      rd(8'h1C, 32'h0, "unmapped");
      check("slverr", lastErr, 1);
      apb(1, OFS_DELAY, 32'hFFFF_FFA5);
      rd(OFS_DELAY, 32'h0000_00A5, "delay rw");
      // lock, events and interrupt
      pllResetN <= 1;
      waitLock(1);
      check("lock", pllLock, 1);
      rd(OFS_IRQ_STAT, 32'h1, "lock gained");
      check("irq masked", irq, 0);
      apb(1, OFS_IRQ_MASK, 32'h7);
      repeat (3) @(posedge clk_sys);
      check("irq", irq, 1);
      apb(1, OFS_IRQ_STAT, 32'h1);
      repeat (3) @(posedge clk_sys);
      check("irq cleared", irq, 0);
      pllResetN <= 0;
      repeat (4) @(posedge clk_sys);
      check("lock in reset", pllLock, 0);
      rd(OFS_IRQ_STAT, 32'h2, "lock lost");
      apb(1, OFS_IRQ_STAT, 32'h7);
      pllResetN <= 1;
      // multiplier and output divider
      for (int i = 0; i < 7; i++) begin
         apb(1, OFS_CTRL, ctl[i]);
         waitLock(1);
         per;
         check("period", p, exP[i]);
      end
      // raw reference of each source in bypass
      bypass <= 1;
      for (int s = 0; s < 4; s++) begin
         apb(1, OFS_CTRL, 32'h40000 | s);
         per;
         check("bypass period", p, srcP[s]);
      end
      bypass <= 0;
      // hold freezes only with both gate enables
      apb(1, OFS_CTRL, 32'h40010);
      hold <= 1;
      per;
      check("gate a only", p, 4);
      apb(1, OFS_CTRL, 32'h40030);
      repeat (3) @(posedge clk_sys);
      v = pllGlobalOutput;
      p = 0;
      repeat (40) begin
         @(posedge clk_sys);
         if (pllGlobalOutput !== v) p++;
      end
      check("frozen", p, 0);
      hold <= 0;
      // external feedback and dynamic delay change
      apb(1, OFS_CTRL, 32'h1000C);
      repeat (200) @(posedge clk_sys);
      waitLock(1);
      check("ext lock", pllLock, 1);
      fineDelayControl <= 8'h05;
      waitLock(0);
      check("lock drop", pllLock, 0);
      waitLock(1);
      check("relock", pllLock, 1);
      // global pins, buffers and logic block selects
      apb(1, OFS_ROUTE, 32'h0001_0062);
      for (int i = 0; i < 2; i++) begin
         globalPin <= i ? 6'h2B : 6'h14;
         repeat (8) @(posedge clk_sys);
         eb = {globalPin[5:4], 2'b00, globalPin[3:0]};
         check("buffers", globalBuffer & 8'hCF, eb);
         check("clock", plbClock, eb[2]);
         check("lut", plbLutIn, {eb[0], eb[0], eb[0], eb[6]});
         check("set reset", plbSetReset, eb[2]);
         check("clock enable", plbClockEnable, eb[1]);
         check("gpio clock use", globalPinGpio, 0);
      end
      apb(1, OFS_GLOBAL_BUFFER, 32'h0000_0F03);
      repeat (8) @(posedge clk_sys);
      check("gpio", globalPinGpio, {globalPin[5:4], 4'h0});
      v = pllGlobalOutput;
      @(posedge clk_sys);
      check("pll buffers", globalBuffer[5:4], {v, v});
      test_done;
   end
endmodule
